//--- common/fesc_pkg.sv
// Constants, types and command encodings for the flash erase/suspend host controller
// Contract
// - Sector erase is six writes: two unlocks, setup, two unlocks, erase at sector.
// - Host erases one sector per sequence and starts the next only after completion.
// - Bit 7 may turn valid before bits 0-6; host takes data from a later read.
// - After bit 5 high, host rechecks bit 6; still toggling means fail, write reset.
// - Host reads status twice in a row; a stable toggle bit means completion.
package fesc_pkg;

    localparam int ADDR_W        = 22;
    localparam int DATA_W        = 16;
    localparam int SEC_HI        = 20;
    localparam int SEC_LO        = 12;
    localparam int BIT_TOGGLE    = 6;
    localparam int BIT_TIMEOUT   = 5;
    localparam int BIT_SEC_TOG   = 2;
    localparam int SYNC_LAT      = 2;
    localparam int ERASE_STEPS   = 6;
    localparam int CNT_W         = 12;

    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002aa;
    localparam logic [ADDR_W-1:0] ANY_ADDR     = 22'h000000;

    localparam logic [DATA_W-1:0] CMD_UNLOCK1     = 16'h00aa;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2     = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_ERASE_CONF  = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_SUSPEND     = 16'h00b0;
    localparam logic [DATA_W-1:0] CMD_RESUME      = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_RESET       = 16'h00f0;

    localparam int CLK_PERIOD_NS = 20;
    localparam int T_SUSPEND_US  = 20;
    localparam int T_ACC_NS      = 90;
    localparam int T_WE_LOW_NS   = 60;
    localparam int SUSPEND_CYC   = (T_SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_LOW_CYC    = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_ERASE   = 3'h1,
        OP_SUSPEND = 3'h2,
        OP_RESUME  = 3'h3,
        OP_RESET   = 3'h4
    } fesc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_WRITE = 3'h1,
        ST_READ  = 3'h2,
        ST_WAIT  = 3'h3,
        ST_EVAL  = 3'h4,
        ST_DONE  = 3'h5
    } fesc_state_t;

    typedef struct packed {
        fesc_op_t          op;
        logic [ADDR_W-1:0] addr;
    } fesc_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              err;
        logic              suspended;
    } fesc_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fesc_wr_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic              dq_oe;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
    } fesc_pins_t;

endpackage

//--- rtl/fesc_ctrl.sv
// Host-side controller for sector erase, suspend/resume and status polling of a NOR flash
`timescale 1ns/1ps
module fesc_ctrl
    import fesc_pkg::*;
#(
    parameter int WE_CYC   = WE_LOW_CYC,
    parameter int RD_CYC   = ACC_CYC,
    parameter int SUSP_CYC = SUSPEND_CYC
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  fesc_cmd_t              cmd,
    input  wire logic              suspend_req,
    output logic                   rsp_valid,
    output fesc_rsp_t              rsp,
    output logic                   busy,
    output logic                   suspended,
    output logic                   flash_ready,
    output fesc_pins_t             pins,
    input  wire logic [DATA_W-1:0] dq_i,
    input  wire logic              ready_busy_n
);

    if (WE_CYC < 1 || RD_CYC < 1 || SUSP_CYC < 1 || SUSP_CYC >= (1 << CNT_W) ||
        WE_CYC + 2 >= (1 << CNT_W) || RD_CYC + SYNC_LAT >= (1 << CNT_W))
    begin : g_chk
        $error("fesc_ctrl: timing parameter out of range");
    end

    localparam logic [CNT_W-1:0] WE_LAST  = CNT_W'(WE_CYC);
    localparam logic [CNT_W-1:0] WR_END   = CNT_W'(WE_CYC + 2);
    localparam logic [CNT_W-1:0] RD_END   = CNT_W'(RD_CYC + SYNC_LAT);
    localparam logic [CNT_W-1:0] WAIT_END = CNT_W'(SUSP_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // Keep only the bits that select a sector
    function automatic logic [ADDR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] m;
        m = '0;
        m[SEC_HI:SEC_LO] = a[SEC_HI:SEC_LO];
        return m;
    endfunction

    function automatic logic [2:0] seq_len(input fesc_op_t op);
        return (op == OP_ERASE) ? 3'(ERASE_STEPS) : 3'h1;
    endfunction

    function automatic fesc_wr_t seq_wr(input fesc_op_t op, input logic [2:0] step,
                                        input logic [ADDR_W-1:0] sec);
        fesc_wr_t w;
        w = '{addr: ANY_ADDR, data: CMD_RESET};
        unique case (op)
            OP_ERASE:
            begin
                unique case (step)
                    3'h0:    w = '{addr: UNLOCK1_ADDR, data: CMD_UNLOCK1};
                    3'h1:    w = '{addr: UNLOCK2_ADDR, data: CMD_UNLOCK2};
                    3'h2:    w = '{addr: UNLOCK1_ADDR, data: CMD_ERASE_SETUP};
                    3'h3:    w = '{addr: UNLOCK1_ADDR, data: CMD_UNLOCK1};
                    3'h4:    w = '{addr: UNLOCK2_ADDR, data: CMD_UNLOCK2};
                    default: w = '{addr: sec, data: CMD_ERASE_CONF};
                endcase
            end
            OP_SUSPEND: w = '{addr: ANY_ADDR, data: CMD_SUSPEND};
            OP_RESUME:  w = '{addr: ANY_ADDR, data: CMD_RESUME};
            OP_RESET:   w = '{addr: ANY_ADDR, data: CMD_RESET};
            default:    w = '{addr: ANY_ADDR, data: CMD_RESET};
        endcase
        return w;
    endfunction

    fesc_state_t       state_q;
    fesc_op_t          op_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [2:0]        step_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] sec_q;
    logic              user_rd_q;
    logic              rd_idx_q;
    logic              recheck_q;
    logic              err_q;
    logic              susp_q;
    logic [DATA_W-1:0] first_q;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] dq_s1_q;
    logic [DATA_W-1:0] dq_s2_q;
    logic              rb_s1_q;
    logic              rb_s2_q;
    fesc_pins_t        pins_q;
    fesc_pins_t        pins_d;

    wire fesc_wr_t cur_wr    = seq_wr(op_q, step_q, sector_of(sec_q));
    wire           wr_end    = (state_q == ST_WRITE) && (cnt_q == WR_END);
    wire           rd_end    = (state_q == ST_READ) && (cnt_q == RD_END);
    wire           wait_end  = (state_q == ST_WAIT) && (cnt_q == WAIT_END);
    wire           last_step = (step_q == seq_len(op_q) - 3'h1);
    // Two reads in a row at the sector: a moving bit 6 means still running
    wire           toggled   = first_q[BIT_TOGGLE] ^ data_q[BIT_TOGGLE];
    wire           dq5_seen  = data_q[BIT_TIMEOUT] | first_q[BIT_TIMEOUT];
    // Bit 2 moves only inside a sector still selected for erasure
    wire           tog_sec   = first_q[BIT_SEC_TOG] ^ data_q[BIT_SEC_TOG];
    // A second erase waits for the suspended one to finish
    wire           erase_blk = susp_q && (cmd.op == OP_ERASE);
    wire           accept    = cmd_valid && cmd_ready;
    wire           in_wr     = (state_q == ST_WRITE);
    wire           in_rd     = (state_q == ST_READ);

    assign cmd_ready   = (state_q == ST_IDLE) && !erase_blk;
    assign rsp_valid   = (state_q == ST_DONE);
    assign rsp         = '{data: data_q, err: err_q, suspended: susp_q};
    assign busy        = (state_q != ST_IDLE);
    assign suspended   = susp_q;
    assign flash_ready = rb_s2_q;
    assign pins        = pins_q;

    // Data is held one cycle past the rising write strobe
    assign pins_d = '{addr:  in_rd ? (user_rd_q ? addr_q : sec_q) : cur_wr.addr,
                      dq_o:  cur_wr.data,
                      dq_oe: in_wr && (cnt_q < WR_END),
                      ce_n:  !((in_wr && cnt_q <= WE_LAST) || (in_rd && cnt_q < RD_END)),
                      we_n:  !(in_wr && cnt_q >= CNT_ONE && cnt_q <= WE_LAST),
                      oe_n:  !(in_rd && cnt_q < RD_END)};

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            pins_q  <= '{addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
        end
        else
        begin
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            rb_s1_q <= ready_busy_n;
            rb_s2_q <= rb_s1_q;
            pins_q  <= pins_d;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q   <= ST_IDLE;
            op_q      <= OP_READ;
            cnt_q     <= '0;
            step_q    <= '0;
            addr_q    <= '0;
            sec_q     <= '0;
            user_rd_q <= 1'b0;
            rd_idx_q  <= 1'b0;
            recheck_q <= 1'b0;
            err_q     <= 1'b0;
            susp_q    <= 1'b0;
            first_q   <= '0;
            data_q    <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + CNT_ONE;
            unique case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    if (accept)
                    begin
                        op_q      <= cmd.op;
                        step_q    <= '0;
                        err_q     <= 1'b0;
                        recheck_q <= 1'b0;
                        addr_q    <= cmd.addr;
                        user_rd_q <= (cmd.op == OP_READ);
                        rd_idx_q  <= 1'b0;
                        if (cmd.op == OP_ERASE)
                            sec_q <= cmd.addr;
                        state_q <= (cmd.op == OP_READ) ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (wr_end)
                    begin
                        cnt_q  <= '0;
                        step_q <= step_q + 3'h1;
                        if (last_step)
                        begin
                            recheck_q <= 1'b0;
                            rd_idx_q  <= 1'b0;
                            user_rd_q <= 1'b0;
                            unique case (op_q)
                                OP_SUSPEND: state_q <= ST_WAIT;
                                OP_RESET:
                                begin
                                    susp_q  <= 1'b0;
                                    state_q <= ST_DONE;
                                end
                                default:    state_q <= ST_READ;
                            endcase
                        end
                    end
                end
                ST_WAIT:
                begin
                    if (wait_end)
                    begin
                        cnt_q   <= '0;
                        state_q <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (rd_end)
                    begin
                        cnt_q <= '0;
                        if (user_rd_q)
                        begin
                            data_q  <= dq_s2_q;
                            state_q <= ST_DONE;
                        end
                        else if (!rd_idx_q)
                        begin
                            first_q  <= dq_s2_q;
                            rd_idx_q <= 1'b1;
                        end
                        else
                        begin
                            data_q  <= dq_s2_q;
                            state_q <= ST_EVAL;
                        end
                    end
                end
                ST_EVAL:
                begin
                    cnt_q    <= '0;
                    rd_idx_q <= 1'b0;
                    state_q  <= ST_READ;
                    if (!toggled)
                    begin
                        // Suspended only if bit 2 still moves; an idle or finished erase reads array data
                        susp_q  <= (op_q == OP_SUSPEND) && tog_sec;
                        state_q <= ST_DONE;
                    end
                    else if (op_q == OP_SUSPEND)
                        state_q <= ST_READ;
                    else if (recheck_q)
                    begin
                        err_q   <= 1'b1;
                        op_q    <= OP_RESET;
                        step_q  <= '0;
                        state_q <= ST_WRITE;
                    end
                    else if (dq5_seen)
                        recheck_q <= 1'b1;
                    else if (suspend_req)
                    begin
                        op_q    <= OP_SUSPEND;
                        step_q  <= '0;
                        state_q <= ST_WRITE;
                    end
                end
                ST_DONE:
                begin
                    // The second polled word is returned as response data; after a finished erase it is array data
                    cnt_q   <= '0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // fesc_ctrl

//--- tb/fesc_ctrl_asserts.sv
// Port checker for the flash erase/suspend host controller
`timescale 1ns/1ps
module fesc_ctrl_asserts
    import fesc_pkg::*;
#(
    parameter int WE_CYC = 3,
    parameter int RD_CYC = 5
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input fesc_cmd_t cmd,
    input wire logic rsp_valid,
    input fesc_rsp_t rsp,
    input wire logic busy,
    input wire logic suspended,
    input fesc_pins_t pins
);
    logic [7:0]  we_cnt_q;
    logic [7:0]  oe_cnt_q;
    logic [15:0] last_wr_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            we_cnt_q  <= 8'h00;
            oe_cnt_q  <= 8'h00;
            last_wr_q <= 16'h0000;
        end
        else
        begin
            we_cnt_q  <= pins.we_n ? 8'h00 : we_cnt_q + 8'h01;
            oe_cnt_q  <= pins.oe_n ? 8'h00 : oe_cnt_q + 8'h01;
            last_wr_q <= pins.we_n ? last_wr_q : pins.dq_o;
        end
    end
    idle_accept_a: assert property (!busy && !(suspended && cmd.op == OP_ERASE) |-> cmd_ready)
        else $error("idle controller refused a request");
    busy_refuse_a: assert property (busy || (suspended && cmd.op == OP_ERASE) |-> !cmd_ready)
        else $error("request taken while busy or suspended");
    take_busy_a: assert property (cmd_valid && cmd_ready |=> busy)
        else $error("taken request left controller idle");
    rsp_single_a: assert property (rsp_valid |-> busy ##1 (!busy && !rsp_valid))
        else $error("response not a single pulse");
    write_strobe_a: assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n && pins.dq_oe)
        else $error("write strobe without select or drive");
    read_release_a: assert property (!pins.oe_n |-> !pins.dq_oe && !pins.ce_n)
        else $error("host drives bus during read");
    we_width_a: assert property ($rose(pins.we_n) |-> we_cnt_q == WE_CYC)
        else $error("write strobe width wrong");
    rd_width_a: assert property ($rose(pins.oe_n) |-> oe_cnt_q == RD_CYC + 2)
        else $error("read strobe width wrong");
    susp_cause_a: assert property ($rose(suspended) |-> last_wr_q == CMD_SUSPEND)
        else $error("suspended without suspend write");
    err_c: cover property (rsp_valid && rsp.err);
    susp_c: cover property ($rose(suspended));
    refuse_c: cover property (suspended && cmd.op == OP_ERASE && !cmd_ready);
endmodule // fesc_ctrl_asserts

bind fesc_ctrl fesc_ctrl_asserts #(.WE_CYC(WE_CYC), .RD_CYC(RD_CYC)) i_fesc_ctrl_asserts (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy), .suspended(suspended), .pins(pins));

//--- tb/fesc_flash_model.sv
// Behavioural flash device for sector erase, suspend and status reads
`timescale 1ns/1ps
module fesc_flash_model
    import fesc_pkg::*;
(
    input fesc_pins_t               pins,
    input wire logic [7:0]          erase_len,
    input wire logic                fail,
    output logic [DATA_W-1:0]       dq_i,
    output logic                    ready_busy_n
);
    localparam logic [ADDR_W-1:0] SEQ_A [0:5] = '{UNLOCK1_ADDR, UNLOCK2_ADDR, UNLOCK1_ADDR,
                                                   UNLOCK1_ADDR, UNLOCK2_ADDR, ANY_ADDR};
    localparam logic [DATA_W-1:0] SEQ_D [0:5] = '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_ERASE_SETUP,
                                                   CMD_UNLOCK1, CMD_UNLOCK2, CMD_ERASE_CONF};
    // Mode 0 array read, 1 erasing, 2 suspended
    logic [1:0]        mode_q = 2'h0;
    logic [2:0]        seq_q  = 3'h0;
    logic [8:0]        sec_q  = 9'h000;
    logic [7:0]        left_q = 8'h00;
    logic              tog_q  = 1'b0;
    logic              dq5_q  = 1'b0;
    logic              done_q = 1'b0;
    logic [DATA_W-1:0] out_q  = 16'h0000;
    logic              insec;
    assign insec = pins.addr[SEC_HI:SEC_LO] == sec_q;
    assign ready_busy_n = mode_q != 2'h1;
    // A released bus shows the inverse word, so stale data never passes as a fresh read
    assign dq_i = (!pins.ce_n && !pins.oe_n) ? out_q : ~out_q;
    always @(posedge pins.we_n)
    begin
        if (mode_q == 2'h1)
        begin
            if (pins.dq_o == CMD_SUSPEND)
                mode_q = 2'h2;
            else if (dq5_q && pins.dq_o == CMD_RESET)
            begin
                mode_q = 2'h0;
                dq5_q = 1'b0;
            end
        end
        else if (mode_q == 2'h2)
        begin
            if (pins.dq_o == CMD_RESUME)
                mode_q = 2'h1;
        end
        else if (pins.dq_o == SEQ_D[seq_q] && (seq_q == 3'h5 || pins.addr == SEQ_A[seq_q]))
        begin
            seq_q = seq_q + 3'h1;
            if (seq_q == 3'h6)
            begin
                seq_q = 3'h0;
                mode_q = 2'h1;
                sec_q = pins.addr[SEC_HI:SEC_LO];
                left_q = erase_len;
                done_q = 1'b0;
            end
        end
        else
            seq_q = 3'h0;
    end
    always @(negedge pins.oe_n)
    begin
        #1;
        tog_q = ~tog_q;
        if (mode_q == 2'h1)
        begin
            out_q = {8'h00, 1'b0, tog_q, dq5_q, 1'b0, 1'b1, tog_q, 2'b00};
            if (left_q != 8'h00)
                left_q = left_q - 8'h01;
            else if (fail)
                dq5_q = 1'b1;
            else
            begin
                mode_q = 2'h0;
                done_q = 1'b1;
            end
        end
        else if (mode_q == 2'h2 && insec)
            out_q = {8'h00, 1'b1, 1'b0, 1'b0, 2'b00, tog_q, 2'b00};
        else
            out_q = (done_q && insec) ? 16'hffff : pins.addr[15:0];
    end
endmodule // fesc_flash_model

//--- tb/tb.sv
// Self-checking bench for the flash erase/suspend host controller
`timescale 1ns/1ps
module tb
    import fesc_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        suspend_req = 1'b0;
    logic        fail = 1'b0;
    logic        ex_ok = 1'b0;
    logic [7:0]  erase_len = 8'h00;
    logic [8:0]  ex_sec = 9'h000;
    logic [21:0] a;
    logic [15:0] prev;
    fesc_cmd_t   cmd = '0;
    fesc_rsp_t   rsp;
    fesc_pins_t  pins;
    logic [15:0] dq_i;
    logic        cmd_ready, rsp_valid, busy, suspended, flash_ready, ready_busy_n;
    int          miscompares = 0;
    int          tests_run = 0;
    int          seed;

    always #10 ref_clk = ~ref_clk;

    fesc_ctrl #(.SUSP_CYC(4)) i_fesc_ctrl (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .suspend_req(suspend_req), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy), .suspended(suspended),
        .flash_ready(flash_ready), .pins(pins), .dq_i(dq_i), .ready_busy_n(ready_busy_n));
    fesc_flash_model i_fesc_flash_model (
        .pins(pins), .erase_len(erase_len), .fail(fail), .dq_i(dq_i), .ready_busy_n(ready_busy_n));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] arr_val(input logic [21:0] ad);
        return (ex_ok && ad[SEC_HI:SEC_LO] == ex_sec) ? 16'hffff : ad[15:0];
    endfunction

    // Called just after a falling edge; request held until the edge that takes it
    task automatic run(input fesc_op_t op, input logic [21:0] addr);
        int n = 0;
        cmd_valid = 1'b1;
        cmd.op = op;
        cmd.addr = addr;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 20000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("response", rsp_valid, 1'b1);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        seed = $urandom(26784);
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        check("ready after reset", {cmd_ready, flash_ready, busy}, 3'h6);
        repeat (4)
        begin
            a = 22'($urandom);
            run(OP_READ, a);
            check("array read", rsp.data, arr_val(a));
        end
        // Back-to-back erases, erase length down to zero
        repeat (3)
        begin
            a = 22'($urandom);
            erase_len = 8'($urandom_range(12));
            run(OP_ERASE, a);
            ex_sec = a[SEC_HI:SEC_LO];
            ex_ok = 1'b1;
            check("erase done", rsp.data, 16'hffff);
            check("erase err", rsp.err, 1'b0);
            run(OP_READ, a);
            check("erased read", rsp.data, 16'hffff);
            a[SEC_LO] = ~a[SEC_LO];
            run(OP_READ, a);
            check("other sector", rsp.data, a[15:0]);
        end
        a = 22'($urandom);
        erase_len = 8'hc8;
        ex_ok = 1'b0;
        suspend_req = 1'b1;
        run(OP_ERASE, a);
        suspend_req = 1'b0;
        check("suspended", {rsp.suspended, suspended, flash_ready}, 3'h7);
        cmd.op = OP_ERASE;
        @(negedge ref_clk);
        check("erase refused", {busy, cmd_ready}, 2'h0);
        run(OP_READ, a);
        prev = rsp.data;
        check("suspend status", {prev[7], prev[5]}, 2'h2);
        run(OP_READ, a);
        check("bit2 toggles", rsp.data[2], !prev[2]);
        check("bit6 steady", rsp.data[6], prev[6]);
        a[SEC_LO] = ~a[SEC_LO];
        run(OP_READ, a);
        check("suspend other", rsp.data, a[15:0]);
        a[SEC_LO] = ~a[SEC_LO];
        repeat (2)
        begin
            run(OP_RESUME, 22'h000000);
            check("resume done", rsp.data, 16'hffff);
            check("resume flag", suspended, 1'b0);
        end
        fail = 1'b1;
        erase_len = 8'h03;
        run(OP_ERASE, a);
        fail = 1'b0;
        check("erase fail", rsp.err, 1'b1);
        run(OP_READ, a);
        check("read after fail", rsp.data, arr_val(a));
        run(OP_SUSPEND, a);
        run(OP_READ, a);
        check("idle suspend", rsp.data, arr_val(a));
        check("idle suspend flag", suspended, 1'b0);
        run(OP_RESET, a);
        check("reset clears", suspended, 1'b0);
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        check("ready after mid reset", {cmd_ready, flash_ready, busy}, 3'h6);
        run(OP_READ, a);
        check("read after mid reset", rsp.data, arr_val(a));
        tally_and_finish();
    end
endmodule // tb
